/* File: hdl/pro_cfg.svh */
`ifndef PRO_CFG_SVH
`define PRO_CFG_SVH
// service action codes
`define PRO_SA_REGISTER 5'h00
`define PRO_SA_RESERVE 5'h01
`define PRO_SA_RELEASE 5'h02
`define PRO_SA_CLEAR 5'h03
`define PRO_SA_PREEMPT 5'h04
`define PRO_SA_PREEMPT_ABORT 5'h05
`define PRO_SA_REGISTER_IGNORE 5'h06
// only accepted parameter list length
`define PRO_PARAM_LEN 16'h0018
// status codes
`define PRO_ST_GOOD 2'h0
`define PRO_ST_CHECK 2'h1
`define PRO_ST_CONFLICT 2'h2
// sense codes
`define PRO_SN_NONE 3'h0
`define PRO_SN_LEN_ERR 3'h1
`define PRO_SN_INV_FIELD 3'h2
`define PRO_SN_NO_RESOURCE 3'h3
`define PRO_SN_BAD_ACTION 3'h4
// register offsets on the plain port
`define PRO_REG_GEN 4'h0
`define PRO_REG_STATE 4'h1
`define PRO_REG_SLOT_KEY_LO 4'h2
`define PRO_REG_SLOT_KEY_HI 4'h3
`define PRO_REG_SLOT_SEL 4'h4
`define PRO_KEY_ZERO 64'h0000000000000000
`endif

/* File: hdl/pro_engine.sv */
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/10ps
module pro_engine import pro_pkg::*; #(
  parameter int NI = 16, // initiators (extra port mask width, one bit per initiator)
  parameter int NT = 4 // target ports
) (
  input wire logic mclk, // 200 MHz clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic power_on, // high for the first cycle after a power cycle
  input wire logic req_valid, // one-cycle request strobe
  input wire pro_req_t req, // request fields
  output pro_resp_t resp, // answer
  output logic resp_valid, // one-cycle answer strobe
  output logic abort_task_set, // pulse: clear task set of preempted holder
  output logic [3:0] abort_initiator, // holder whose task set is aborted
  input wire logic [3:0] reg_addr, // register address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata // read data, cycle after strobe
);
  ////////////////////////////////////////////////////////////////////////////
  // storage: one key per initiator and target port, flattened index
  localparam int NS = NI * NT;
  logic [63:0] key_reg [NS];
  logic [63:0] key_next [NS];
  logic res_active_reg, res_active_next;
  logic [3:0] res_holder_reg, res_holder_next;
  logic [3:0] res_scope_reg, res_scope_next;
  logic [3:0] res_type_reg, res_type_next;
  logic aptpl_reg, aptpl_next;
  logic [31:0] gen_reg, gen_next;
  logic [5:0] slot_sel_reg;
  pro_state_t state_reg;
  pro_req_t req_reg;
  pro_resp_t resp_next;
  logic abort_next;

  function automatic int unsigned slot(input logic [3:0] ini, input logic [1:0] tp);
    slot = int'(ini) * NT + int'(tp);
  endfunction

  function automatic logic is_reg_action(input logic [4:0] a);
    is_reg_action = (a == `PRO_SA_REGISTER) || (a == `PRO_SA_REGISTER_IGNORE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decoded views of the captured request
  wire logic reg_act = is_reg_action(req_reg.action);
  wire logic preempt_act = (req_reg.action == `PRO_SA_PREEMPT) ||
                           (req_reg.action == `PRO_SA_PREEMPT_ABORT);
  wire logic [63:0] own_key = key_reg[slot(req_reg.initiator, req_reg.tport)];
  wire logic key_ok = (own_key == req_reg.res_key);
  // key match found under another initiator means the requester used a foreign key
  logic foreign_key;
  always_comb begin
    foreign_key = 1'b0;
    for (int i = 0; i < NS; i++) begin
      if ((i / NT) != int'(req_reg.initiator) && key_reg[i] == req_reg.res_key &&
          req_reg.res_key != `PRO_KEY_ZERO) begin
        foreign_key = 1'b1;
      end
    end
  end
  // a listed port is out of room only when its index is NI or more, which the
  // loop never reaches, so no_room stays low; zero key means unregister
  logic no_room;
  always_comb begin
    no_room = 1'b0;
    for (int i = 0; i < NI; i++) begin
      if (req_reg.extra_ports[i] && i >= NI) begin
        no_room = 1'b1;
      end
    end
  end
  wire logic holder_match = res_active_reg &&
    (key_reg[slot(res_holder_reg, req_reg.tport)] == req_reg.sa_key);

  ////////////////////////////////////////////////////////////////////////////
  // command evaluation: checks in priority order, then effects
  always_comb begin
    key_next = key_reg;
    res_active_next = res_active_reg;
    res_holder_next = res_holder_reg;
    res_scope_next = res_scope_reg;
    res_type_next = res_type_reg;
    aptpl_next = aptpl_reg;
    gen_next = gen_reg;
    abort_next = 1'b0;
    resp_next = '{status: `PRO_ST_GOOD, sense: `PRO_SN_NONE};
    if (req_reg.conv_reserved) begin
      resp_next.status = `PRO_ST_CONFLICT;
    end else if (req_reg.param_len != `PRO_PARAM_LEN) begin
      resp_next = '{status: `PRO_ST_CHECK, sense: `PRO_SN_LEN_ERR};
    end else if (req_reg.action > `PRO_SA_REGISTER_IGNORE) begin
      resp_next = '{status: `PRO_ST_CHECK, sense: `PRO_SN_BAD_ACTION};
    end else if (req_reg.spec_i_pt && req_reg.action != `PRO_SA_REGISTER) begin
      resp_next = '{status: `PRO_ST_CHECK, sense: `PRO_SN_INV_FIELD};
    end else if (foreign_key) begin
      resp_next.status = `PRO_ST_CONFLICT;
    end else if (!reg_act && !key_ok) begin
      resp_next.status = `PRO_ST_CONFLICT;
    end else if (req_reg.action == `PRO_SA_REGISTER && !key_ok && own_key != `PRO_KEY_ZERO) begin
      resp_next.status = `PRO_ST_CONFLICT; // plain register must know the old key
    end else if (reg_act && req_reg.spec_i_pt && no_room) begin
      resp_next = '{status: `PRO_ST_CHECK, sense: `PRO_SN_NO_RESOURCE};
    end else if (reg_act) begin
      // scope and type are not looked at here
      for (int i = 0; i < NI; i++) begin
        for (int t = 0; t < NT; t++) begin
          if ((i == int'(req_reg.initiator) ||
               (req_reg.spec_i_pt && req_reg.extra_ports[i])) &&
              (req_reg.all_tg_pt || t == int'(req_reg.tport))) begin
            key_next[i * NT + t] = req_reg.sa_key;
          end
        end
      end
      aptpl_next = req_reg.aptpl;
      gen_next = gen_reg + 32'h00000001;
    end else if (req_reg.action == `PRO_SA_RESERVE) begin
      if (res_active_reg && res_holder_reg != req_reg.initiator) begin
        resp_next.status = `PRO_ST_CONFLICT;
      end else begin
        res_active_next = 1'b1;
        res_holder_next = req_reg.initiator;
        res_scope_next = req_reg.scope;
        res_type_next = req_reg.rtype;
      end
    end else if (req_reg.action == `PRO_SA_RELEASE) begin
      if (res_active_reg && res_holder_reg == req_reg.initiator &&
          res_scope_reg == req_reg.scope && res_type_reg == req_reg.rtype) begin
        res_active_next = 1'b0;
      end
    end else if (req_reg.action == `PRO_SA_CLEAR) begin
      for (int i = 0; i < NS; i++) begin
        key_next[i] = `PRO_KEY_ZERO;
      end
      res_active_next = 1'b0;
    end else if (preempt_act) begin
      if (holder_match) begin
        abort_next = (req_reg.action == `PRO_SA_PREEMPT_ABORT);
        res_holder_next = req_reg.initiator;
        res_scope_next = req_reg.scope;
        res_type_next = req_reg.rtype;
      end
      gen_next = gen_reg + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: capture, evaluate, answer; the far side sends full lists
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= PRO_IDLE;
      resp_valid <= 1'b0;
      resp <= '0;
      abort_task_set <= 1'b0;
      abort_initiator <= 4'h0;
      req_reg <= '0;
    end else begin
      resp_valid <= 1'b0;
      abort_task_set <= 1'b0;
      case (state_reg)
        PRO_IDLE: begin
          if (req_valid && !power_on) begin
            req_reg <= req;
            state_reg <= PRO_EXEC;
          end
        end
        PRO_EXEC: begin
          resp <= resp_next;
          resp_valid <= 1'b1;
          abort_task_set <= abort_next;
          abort_initiator <= res_holder_reg;
          state_reg <= PRO_DONE;
        end
        PRO_DONE: state_reg <= PRO_IDLE;
        default: state_reg <= PRO_IDLE;
      endcase
    end
  end

  // persistent state; power_on models the power cycle, sys_rst leaves keys
  // alone so that a retained set survives a plain logic reset; an unset
  // persist flag (first power-up) takes the clearing branch, so no key starts unknown
  always_ff @(posedge mclk) begin
    if (power_on) begin
      gen_reg <= 32'h00000000;
      if (aptpl_reg) begin
        aptpl_reg <= 1'b1; // retained
      end else begin
        for (int i = 0; i < NS; i++) key_reg[i] <= `PRO_KEY_ZERO;
        res_active_reg <= 1'b0;
        res_holder_reg <= 4'h0;
        res_scope_reg <= 4'h0;
        res_type_reg <= 4'h0;
        aptpl_reg <= 1'b0;
      end
    end else if (sys_rst) begin
      gen_reg <= 32'h00000000;
    end else if (state_reg == PRO_EXEC) begin
      key_reg <= key_next;
      res_active_reg <= res_active_next;
      res_holder_reg <= res_holder_next;
      res_scope_reg <= res_scope_next;
      res_type_reg <= res_type_next;
      aptpl_reg <= aptpl_next;
      gen_reg <= gen_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port: generation, reservation state, slot key viewer
  wire logic [63:0] view_key = key_reg[slot_sel_reg];
  wire logic [31:0] rd_mux =
    (reg_addr == `PRO_REG_GEN) ? gen_reg :
    (reg_addr == `PRO_REG_STATE) ? {17'h0, aptpl_reg, res_type_reg, res_scope_reg,
                                    res_holder_reg, 1'b0, res_active_reg} :
    (reg_addr == `PRO_REG_SLOT_KEY_LO) ? view_key[31:0] :
    (reg_addr == `PRO_REG_SLOT_KEY_HI) ? view_key[63:32] :
    (reg_addr == `PRO_REG_SLOT_SEL) ? {26'h0, slot_sel_reg} : 32'h00000000;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
      slot_sel_reg <= 6'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      if (reg_wr && reg_addr == `PRO_REG_SLOT_SEL) slot_sel_reg <= reg_wdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_gen_counts: assert property (@(posedge mclk) disable iff (sys_rst || power_on)
    (state_reg == PRO_EXEC && resp_next.status == `PRO_ST_GOOD && reg_act) |=>
    gen_reg == $past(gen_reg) + 32'h00000001) else $error("gen not bumped");
  a_len_check: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg == PRO_EXEC && !req_reg.conv_reserved && req_reg.param_len != `PRO_PARAM_LEN)
    |=> resp_valid && resp.sense == `PRO_SN_LEN_ERR) else $error("length err");
  a_conv_conflict: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg == PRO_EXEC && req_reg.conv_reserved) |=> resp.status == `PRO_ST_CONFLICT)
    else $error("conv reserve");
  a_spec_field: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg == PRO_EXEC && resp_next.sense == `PRO_SN_INV_FIELD) |->
    req_reg.spec_i_pt && req_reg.action != `PRO_SA_REGISTER) else $error("spec");
  a_key_cmp: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg == PRO_EXEC && !reg_act && resp_next.status == `PRO_ST_GOOD) |-> key_ok)
    else $error("key bypass");
  a_gen_zero: assert property (@(posedge mclk) power_on |=> gen_reg == 32'h0)
    else $error("gen not cleared");
  a_aptpl_other: assert property (@(posedge mclk) disable iff (sys_rst || power_on)
    (state_reg == PRO_EXEC && !reg_act) |=> $stable(aptpl_reg))
    else $error("aptpl changed");
  a_resp_time: assert property (@(posedge mclk) disable iff (sys_rst || power_on)
    (state_reg == PRO_IDLE && req_valid) |-> ##2 resp_valid) else $error("late");
  c_register: cover property (@(posedge mclk) resp_valid && resp.status == `PRO_ST_GOOD);
  c_conflict: cover property (@(posedge mclk) resp_valid && resp.status == `PRO_ST_CONFLICT);
  c_abort: cover property (@(posedge mclk) abort_task_set);
endmodule // pro_engine

/* File: hdl/pro_pkg.sv */
package pro_pkg;
  `include "pro_cfg.svh"
  // one reservation-out request as delivered by the command layer
  typedef struct packed {
    logic [4:0] action;
    logic [3:0] scope;
    logic [3:0] rtype;
    logic [15:0] param_len;
    logic [63:0] res_key;
    logic [63:0] sa_key;
    logic spec_i_pt;
    logic all_tg_pt;
    logic aptpl;
    logic [3:0] initiator;
    logic [1:0] tport;
    logic [15:0] extra_ports;
    logic conv_reserved;
  } pro_req_t;
  // completion answer
  typedef struct packed {
    logic [1:0] status;
    logic [2:0] sense;
  } pro_resp_t;
  typedef enum logic [2:0] {
    PRO_IDLE = 3'b001,
    PRO_EXEC = 3'b010,
    PRO_DONE = 3'b100
  } pro_state_t;
endpackage

/* File: sim/persistent_reserve_out_params_bench.sv */
`timescale 1ns/10ps
`include "pro_cfg.svh"
module persistent_reserve_out_params_bench import pro_pkg::*;;
  typedef struct packed {
    logic [4:0] act;
    logic [3:0] ini;
    logic [7:0] rk;
    logic [7:0] sk;
    logic sp;
    logic ap;
    logic [15:0] len;
    logic cv;
    logic [4:0] exp;
  } pro_row_t;
  logic mclk = 1'b0, sys_rst = 1'b1, power_on = 1'b0, send = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic req_valid, resp_valid, abort_task_set, ab;
  logic [3:0] reg_addr = 4'h0, abort_initiator, ai;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [63:0] k;
  pro_req_t cmd = '0, req, q;
  pro_resp_t resp, r;
  pro_row_t rows [12];
  int fails = 0, checks = 0, egen = 0;
  pro_host u_host (.mclk(mclk), .send(send), .cmd(cmd), .req_valid(req_valid), .req(req));
  pro_engine u_dut (.mclk(mclk), .sys_rst(sys_rst), .power_on(power_on), .req_valid(req_valid),
    .req(req), .resp(resp), .resp_valid(resp_valid), .abort_task_set(abort_task_set),
    .abort_initiator(abort_initiator), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; a run is a few hundred cycles, so this is generous
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task cmp_resp(input string n, input logic [4:0] e, input pro_resp_t g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task cmp_reg(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // register port: one-cycle strobes, read data looked at in the cycle after
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask
  task slot(input int s, output logic [63:0] kv);
    logic [31:0] lo, hi;
    wr(`PRO_REG_SLOT_SEL, 32'(s));
    rd(`PRO_REG_SLOT_KEY_LO, lo);
    rd(`PRO_REG_SLOT_KEY_HI, hi);
    kv = {hi, lo};
  endtask
  // bounded wait for the answer; an absent answer leaves an illegal status behind
  task do_cmd(input pro_req_t c);
    @(posedge mclk);
    send <= 1'b1;
    cmd <= c;
    @(posedge mclk);
    send <= 1'b0;
    ab = 1'b0;
    ai = 4'h0;
    r = '1;
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk);
      if (abort_task_set === 1'b1) begin
        ab = 1'b1;
        ai = abort_initiator;
      end
      if (resp_valid === 1'b1) break;
    end
    if (resp_valid === 1'b1) r = resp;
  endtask
  function automatic pro_req_t mk(input pro_row_t w);
    pro_req_t x;
    x = '0;
    x.action = w.act;
    x.rtype = 4'h1;
    x.param_len = w.len;
    x.res_key = {8{w.rk}};
    x.sa_key = {8{w.sk}};
    x.spec_i_pt = w.sp;
    x.aptpl = w.ap;
    x.initiator = w.ini;
    x.conv_reserved = w.cv;
    return x;
  endfunction
  task power_cycle;
    @(posedge mclk);
    power_on <= 1'b1;
    @(posedge mclk);
    power_on <= 1'b0;
    egen = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // rows: action, initiator, key bytes, flags, length, conventional reserve, answer
  initial begin
    rows = '{
      '{`PRO_SA_REGISTER, 1, 8'h00, 8'h11, 0, 0, 16'h0018, 0, 5'h00},
      '{`PRO_SA_REGISTER, 2, 8'h00, 8'h22, 0, 1, 16'h0018, 0, 5'h00},
      '{`PRO_SA_RESERVE, 1, 8'h11, 8'h00, 0, 0, 16'h0018, 0, 5'h00},
      '{`PRO_SA_RESERVE, 1, 8'h22, 8'h00, 0, 0, 16'h0018, 0, 5'h10},
      '{5'h07, 1, 8'h11, 8'h00, 0, 0, 16'h0018, 0, 5'h0c},
      '{`PRO_SA_RESERVE, 1, 8'h11, 8'h00, 0, 0, 16'h0017, 0, 5'h09},
      '{`PRO_SA_RESERVE, 1, 8'h11, 8'h00, 1, 0, 16'h0018, 0, 5'h0a},
      '{`PRO_SA_RESERVE, 1, 8'h11, 8'h00, 0, 0, 16'h0018, 1, 5'h10},
      '{`PRO_SA_PREEMPT, 2, 8'h22, 8'h11, 0, 0, 16'h0018, 0, 5'h00},
      '{`PRO_SA_RELEASE, 2, 8'h22, 8'h00, 0, 0, 16'h0018, 0, 5'h00},
      '{`PRO_SA_REGISTER_IGNORE, 3, 8'h5a, 8'h33, 0, 0, 16'h0018, 0, 5'h00},
      '{`PRO_SA_CLEAR, 3, 8'h33, 8'h00, 0, 0, 16'h0018, 0, 5'h00}};
    // first power-up happens inside the reset span so the key store starts cleared
    @(posedge mclk);
    power_on <= 1'b1;
    @(posedge mclk);
    power_on <= 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`PRO_REG_GEN, d);
    cmp_reg("gen after reset", 64'h0, {32'h0, d});
    rd(4'hf, d);
    cmp_reg("unmapped read", 64'h0, {32'h0, d});
    $display("test reset done");
    foreach (rows[i]) begin
      do_cmd(mk(rows[i]));
      cmp_resp("row answer", rows[i].exp, r);
      if (rows[i].exp == 5'h00 && rows[i].act inside {5'h00, 5'h04, 5'h05, 5'h06}) egen++;
      rd(`PRO_REG_GEN, d);
      cmp_reg("generation", 64'(egen), {32'h0, d});
    end
    $display("test table done");
    // every known target port gets the key when all-target-ports is set
    q = mk(rows[0]);
    q.initiator = 4'h4;
    q.sa_key = {8{8'h44}};
    q.all_tg_pt = 1'b1;
    do_cmd(q);
    egen++;
    for (int t = 0; t < 4; t++) begin
      slot(16 + t, k);
      cmp_reg("all ports key", {8{8'h44}}, k);
    end
    // initiator port list on target port 2: sender and listed port only
    q = mk(rows[0]);
    q.initiator = 4'h5;
    q.tport = 2'h2;
    q.sa_key = {8{8'h55}};
    q.spec_i_pt = 1'b1;
    q.extra_ports = 16'h0040;
    do_cmd(q);
    egen++;
    slot(22, k);
    cmp_reg("sender key", {8{8'h55}}, k);
    slot(26, k);
    cmp_reg("listed port key", {8{8'h55}}, k);
    slot(21, k);
    cmp_reg("other port key", 64'h0, k);
    $display("test ports done");
    // preempt and abort of the holder of key 44
    do_cmd(mk('{`PRO_SA_RESERVE, 4, 8'h44, 8'h00, 0, 0, 16'h0018, 0, 5'h00}));
    // key 44 is the holder's own key on target port 2, so the holder preempts itself
    q = mk('{`PRO_SA_PREEMPT_ABORT, 4, 8'h44, 8'h44, 0, 0, 16'h0018, 0, 5'h00});
    q.tport = 2'h2;
    do_cmd(q);
    egen++;
    cmp_resp("preempt answer", 5'h00, r);
    cmp_reg("abort holder", 64'h14, {59'h0, ab, ai});
    rd(`PRO_REG_GEN, d);
    cmp_reg("gen after preempt", 64'(egen), {32'h0, d});
    $display("test preempt done");
    // persist flag 1 keeps keys, the counter always restarts
    do_cmd(mk('{`PRO_SA_REGISTER_IGNORE, 7, 8'h00, 8'h77, 0, 1, 16'h0018, 0, 5'h00}));
    power_cycle();
    rd(`PRO_REG_GEN, d);
    cmp_reg("gen after power", 64'h0, {32'h0, d});
    slot(28, k);
    cmp_reg("kept key", {8{8'h77}}, k);
    // persist flag 0, then a release whose set flag must not count
    do_cmd(mk('{`PRO_SA_REGISTER_IGNORE, 7, 8'h00, 8'h78, 0, 0, 16'h0018, 0, 5'h00}));
    do_cmd(mk('{`PRO_SA_RELEASE, 7, 8'h78, 8'h00, 0, 1, 16'h0018, 0, 5'h00}));
    power_cycle();
    slot(28, k);
    cmp_reg("cleared key", 64'h0, k);
    rd(`PRO_REG_STATE, d);
    cmp_reg("reservation gone", 64'h0, {63'h0, d[0]});
    $display("test power done");
    wrap_up();
  end
endmodule // persistent_reserve_out_params_bench

/* File: sim/pro_host.sv */
`timescale 1ns/10ps
module pro_host import pro_pkg::*; (
  input wire logic mclk, // clock
  input wire logic send, // bench asks for one request
  input wire pro_req_t cmd, // request to deliver
  output logic req_valid, // one-cycle request strobe
  output pro_req_t req // request fields
);
  ////////////////////////////////////////////////////////////////////////////////
  // the whole parameter list goes out with every request; between requests the
  // lines carry the inverse of the last value so a stale field is never taken
  always @(posedge mclk) begin
    req_valid <= send;
    if (send) begin
      req <= cmd;
    end else begin
      req <= ~req;
    end
  end
endmodule // pro_host
